// file: rtl/vid_dispatch.sv
// Interrupt and exception dispatch while in 8086-compatibility mode.
// Assumes core clock, async active-high reset, strobes one cycle wide.
// Functional notes
// - Exceptions and NMI in compatibility mode are class 1; maskable interrupts are too unless mode extensions are on.
// - Maskable interrupts form class 2 only with mode extensions enabled.
// - Software interrupt instruction is class 3; breakpoint form is flagged.
// - I/O privilege bits 12-13 gate virtual flags only; class 3 routing does not use them.
// - Control register four bit 0 enables mode extensions.
// - 256-flag redirection bitmap picks program or protected handler.
// - Without extensions, maskable interrupts take the class 1 path.
// - Conforming or nonzero-privilege target raises protection fault, selector error.
// - Gate entry first switches to protected operation at privilege 0.
// - Push IP, CS, flags, SP, SS, ES, DS, FS, GS to kernel stack.
// - Clear data segment registers after saving; later return does not fault.
// - Clear mode, nested, resume, step flags; interrupt gate clears enable.
// - Return reloads flags and segments, re-entering mode if saved flag set.
// - Return changes mode flag only at privilege 0.
// - Protection faults are delivered on vector 13.
// - Extensions with I/O privilege below 3 activate flags at bits 19, 20.
`timescale 1ns/10ps
module vid_dispatch (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Event strobes
    input wire logic i_exc_evt,
    input wire logic i_nmi_evt,
    input wire logic i_maskable_evt,
    input wire logic i_soft_int_evt,
    input wire logic [7:0] i_vector,
    // Control and task state
    input wire logic [31:0] i_control_reg_four,
    input wire logic [255:0] i_redir_map,
    // Selected gate descriptor
    input wire logic [1:0] i_gate_kind,
    input wire logic i_gate_conforming,
    input wire logic [1:0] i_gate_target_dpl,
    input wire logic [15:0] i_gate_selector,
    // Live processor state to save
    input wire logic [31:0] i_instruction_pointer,
    input wire logic [31:0] i_stack_pointer,
    input wire logic [15:0] i_cs,
    input wire logic [15:0] i_ss,
    input wire logic [15:0] i_es,
    input wire logic [15:0] i_ds,
    input wire logic [15:0] i_fs,
    input wire logic [15:0] i_gs,
    input wire logic [31:0] i_flags_load,
    input wire logic i_flags_load_en,
    // Return instruction with popped images
    input wire logic i_interrupt_return_instr_req,
    input wire logic [31:0] i_interrupt_return_instr_flags,
    input wire logic [15:0] i_interrupt_return_instr_es,
    input wire logic [15:0] i_interrupt_return_instr_ds,
    input wire logic [15:0] i_interrupt_return_instr_fs,
    input wire logic [15:0] i_interrupt_return_instr_gs,
    // Status and dispatch results
    output logic [31:0] o_flags_register,
    output logic [1:0] o_current_privilege_level,
    output logic o_prot32,
    output logic [1:0] o_event_class,
    output logic o_breakpoint,
    output logic o_redirect_to_program,
    output logic o_task_switch_req,
    output logic o_gp_fault,
    output logic [15:0] o_gp_error_code,
    output logic [7:0] o_handler_vector,
    output logic o_handler_start,
    output logic o_busy,
    // Stack push stream
    output logic o_push_valid,
    output logic [3:0] o_push_slot,
    output logic [31:0] o_push_data,
    // Data segment registers
    output logic [15:0] o_es,
    output logic [15:0] o_ds,
    output logic [15:0] o_fs,
    output logic [15:0] o_gs
);
    vid_pkg::vid_state_t state;
    logic [1:0] cls;
    logic brk;
    logic redir;
    logic virq_on;
    logic vme_on;
    logic any_evt;
    logic [7:0] vec;
    logic [1:0] gate;
    logic [31:0] save [vid_pkg::SAVE_SLOTS];
    logic [3:0] slot;
    assign vme_on = i_control_reg_four[vid_pkg::CR4_VME_BIT];
    assign any_evt = i_exc_evt | i_nmi_evt | i_maskable_evt | i_soft_int_evt;
    vid_classify u_classify (
        .i_is_exception(i_exc_evt),
        .i_is_nmi(i_nmi_evt),
        .i_is_maskable(i_maskable_evt),
        .i_is_soft_int(i_soft_int_evt),
        .i_vector(i_vector),
        .i_vme_on(vme_on),
        .i_io_privilege_level(o_flags_register[vid_pkg::FLG_IO_PRIVILEGE_LEVEL_HI:vid_pkg::FLG_IO_PRIVILEGE_LEVEL_LO]),
        .i_redir_map(i_redir_map),
        .o_class(cls),
        .o_breakpoint(brk),
        .o_redirect(redir),
        .o_virq_active(virq_on)
    );
    function automatic logic bad_target(input logic conf, input logic [1:0] dpl);
        bad_target = conf || (dpl != vid_pkg::PRIV_KERNEL);
    endfunction
    // ==========================================================
    // Gate entry sequencer
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= vid_pkg::VID_IDLE;
            slot <= 4'h0;
        end else begin
            case (state)
                vid_pkg::VID_IDLE: begin
                    // Every event except a redirected class 3 (class 1, class 2, other class 3) goes through a gate
                    if (any_evt && o_flags_register[vid_pkg::FLG_V86] && !redir) begin
                        state <= vid_pkg::VID_CHECK;
                    end
                end
                vid_pkg::VID_CHECK: begin
                    if (i_gate_kind == vid_pkg::GATE_TASK
                        || bad_target(i_gate_conforming, i_gate_target_dpl)) begin
                        state <= vid_pkg::VID_IDLE;
                    end else begin
                        state <= vid_pkg::VID_SWITCH;
                    end
                end
                vid_pkg::VID_SWITCH: begin
                    state <= vid_pkg::VID_PUSH;
                    slot <= 4'h0;
                end
                vid_pkg::VID_PUSH: begin
                    if (slot == vid_pkg::SLOT_LAST) begin
                        state <= vid_pkg::VID_CLEAR;
                    end else begin
                        slot <= slot + 4'h1;
                    end
                end
                vid_pkg::VID_CLEAR: state <= vid_pkg::VID_RUN;
                vid_pkg::VID_RUN: state <= vid_pkg::VID_IDLE;
                default: state <= vid_pkg::VID_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Event capture and classification results
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vec <= 8'h00;
            gate <= vid_pkg::GATE_INTR;
            o_event_class <= 2'h0;
            o_breakpoint <= 1'b0;
            o_redirect_to_program <= 1'b0;
        end else begin
            o_redirect_to_program <= 1'b0;
            if (state == vid_pkg::VID_IDLE && any_evt && o_flags_register[vid_pkg::FLG_V86]) begin
                vec <= i_vector;
                o_event_class <= cls;
                o_breakpoint <= brk;
                o_redirect_to_program <= redir;
            end
            if (state == vid_pkg::VID_CHECK) begin
                gate <= i_gate_kind;
            end
        end
    end

    // ==========================================================
    // Fault, task switch and handler start
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gp_fault <= 1'b0;
            o_gp_error_code <= vid_pkg::SEG_NULL;
            o_task_switch_req <= 1'b0;
            o_handler_start <= 1'b0;
            o_handler_vector <= 8'h00;
        end else begin
            o_gp_fault <= 1'b0;
            o_task_switch_req <= 1'b0;
            o_handler_start <= 1'b0;
            if (state == vid_pkg::VID_CHECK) begin
                if (i_gate_kind == vid_pkg::GATE_TASK) begin
                    o_task_switch_req <= 1'b1;
                    o_handler_vector <= vec;
                end else if (bad_target(i_gate_conforming, i_gate_target_dpl)) begin
                    o_gp_fault <= 1'b1;
                    o_gp_error_code <= i_gate_selector;
                    o_handler_vector <= vid_pkg::VEC_GP_FAULT;
                end
            end
            if (state == vid_pkg::VID_RUN) begin
                o_handler_start <= 1'b1;
                o_handler_vector <= vec;
            end
        end
    end

    // ==========================================================
    // Privilege and operating mode
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_current_privilege_level <= vid_pkg::PRIV_KERNEL;
            o_prot32 <= 1'b0;
        end else if (state == vid_pkg::VID_SWITCH) begin
            o_current_privilege_level <= vid_pkg::PRIV_KERNEL;
            o_prot32 <= 1'b1;
        end else if (i_interrupt_return_instr_req && o_current_privilege_level == vid_pkg::PRIV_KERNEL
                     && i_interrupt_return_instr_flags[vid_pkg::FLG_V86]) begin
            o_current_privilege_level <= vid_pkg::PRIV_USER;
        end
    end

    // ==========================================================
    // Save frame capture and push stream
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < vid_pkg::SAVE_SLOTS; k++) begin
                save[k] <= 32'h0000_0000;
            end
        end else if (state == vid_pkg::VID_SWITCH) begin
            save[vid_pkg::SLOT_IP] <= i_instruction_pointer;
            save[vid_pkg::SLOT_CS] <= {16'h0000, i_cs};
            save[vid_pkg::SLOT_FLAGS] <= o_flags_register;
            save[vid_pkg::SLOT_SP] <= i_stack_pointer;
            save[vid_pkg::SLOT_SS] <= {16'h0000, i_ss};
            save[vid_pkg::SLOT_ES] <= {16'h0000, o_es};
            save[vid_pkg::SLOT_DS] <= {16'h0000, o_ds};
            save[vid_pkg::SLOT_FS] <= {16'h0000, o_fs};
            save[vid_pkg::SLOT_GS] <= {16'h0000, o_gs};
        end
    end
    always_comb begin
        o_push_valid = (state == vid_pkg::VID_PUSH);
        o_push_slot = slot;
        o_push_data = save[slot];
        o_busy = (state != vid_pkg::VID_IDLE);
    end

    // ==========================================================
    // Data segment registers
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_es <= vid_pkg::SEG_NULL;
            o_ds <= vid_pkg::SEG_NULL;
            o_fs <= vid_pkg::SEG_NULL;
            o_gs <= vid_pkg::SEG_NULL;
        end else if (state == vid_pkg::VID_CLEAR) begin
            o_es <= vid_pkg::SEG_NULL;
            o_ds <= vid_pkg::SEG_NULL;
            o_fs <= vid_pkg::SEG_NULL;
            o_gs <= vid_pkg::SEG_NULL;
        end else if (i_interrupt_return_instr_req) begin
            o_es <= i_interrupt_return_instr_es;
            o_ds <= i_interrupt_return_instr_ds;
            o_fs <= i_interrupt_return_instr_fs;
            o_gs <= i_interrupt_return_instr_gs;
        end else if (state == vid_pkg::VID_IDLE) begin
            o_es <= i_es;
            o_ds <= i_ds;
            o_fs <= i_fs;
            o_gs <= i_gs;
        end
    end

    // ==========================================================
    // Flag register
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_flags_register <= vid_pkg::FLAGS_RESET;
        end else if (state == vid_pkg::VID_CLEAR) begin
            o_flags_register[vid_pkg::FLG_V86] <= 1'b0;
            o_flags_register[vid_pkg::FLG_NEST] <= 1'b0;
            o_flags_register[vid_pkg::FLG_RESUME] <= 1'b0;
            o_flags_register[vid_pkg::FLG_STEP] <= 1'b0;
            if (gate == vid_pkg::GATE_INTR) begin
                o_flags_register[vid_pkg::FLG_IRQ_EN] <= 1'b0;
            end
        end else if (i_interrupt_return_instr_req) begin
            o_flags_register <= i_interrupt_return_instr_flags;
            if (o_current_privilege_level != vid_pkg::PRIV_KERNEL) begin
                o_flags_register[vid_pkg::FLG_V86] <= o_flags_register[vid_pkg::FLG_V86];
            end
            if (!virq_on) begin
                o_flags_register[vid_pkg::FLG_VIRQ] <= 1'b0;
                o_flags_register[vid_pkg::FLG_VPEND] <= 1'b0;
            end
        end else if (i_flags_load_en) begin
            o_flags_register <= i_flags_load;
        end
    end

    // ==========================================================
    // Checks
    sequence gate_ok_s;
        state == vid_pkg::VID_CHECK && i_gate_kind != vid_pkg::GATE_TASK
            && !bad_target(i_gate_conforming, i_gate_target_dpl);
    endsequence
    sequence entry_s;
        ##1 (state == vid_pkg::VID_SWITCH) ##1 o_push_valid [*8]
            ##1 o_push_valid ##1 (state == vid_pkg::VID_CLEAR);
    endsequence
    entry_seq_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        gate_ok_s |-> entry_s)
        else $error("gate entry sequence wrong");
    priv_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_SWITCH |=> o_current_privilege_level == vid_pkg::PRIV_KERNEL && o_prot32)
        else $error("entry not at privilege zero");
    seg_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_CLEAR |=> o_ds == vid_pkg::SEG_NULL && o_gs == vid_pkg::SEG_NULL)
        else $error("segments not cleared");
    flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_CLEAR && gate == vid_pkg::GATE_INTR
            |=> !o_flags_register[vid_pkg::FLG_V86] && !o_flags_register[vid_pkg::FLG_IRQ_EN])
        else $error("entry flags not cleared");
    gp_code_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_CHECK && i_gate_kind != vid_pkg::GATE_TASK && i_gate_conforming
            |=> o_gp_fault && o_gp_error_code == $past(i_gate_selector)
                && o_handler_vector == vid_pkg::VEC_GP_FAULT)
        else $error("protection fault not raised");
    vm_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_interrupt_return_instr_req && state == vid_pkg::VID_IDLE
            && o_current_privilege_level != vid_pkg::PRIV_KERNEL
            |=> $stable(o_flags_register[vid_pkg::FLG_V86]))
        else $error("mode flag changed off privilege zero");
    class_two_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_IDLE && o_flags_register[vid_pkg::FLG_V86] && i_maskable_evt
            && !i_soft_int_evt |=> o_event_class == (vme_on ? vid_pkg::CLASS_TWO : vid_pkg::CLASS_ONE))
        else $error("maskable class wrong");
    soft_class_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        state == vid_pkg::VID_IDLE && o_flags_register[vid_pkg::FLG_V86] && i_soft_int_evt
            |=> o_event_class == vid_pkg::CLASS_THREE)
        else $error("software interrupt class wrong");
endmodule // vid_dispatch

// file: rtl/vid_pkg.sv
// Package for the compatibility-mode interrupt dispatch block.
// Assumes a single core clock domain; no bus, all controls are ports.
package vid_pkg;

    // ==========================================================
    // Flag register field positions
    localparam int FLG_STEP = 8;
    localparam int FLG_IRQ_EN = 9;
    localparam int FLG_IO_PRIVILEGE_LEVEL_LO = 12;
    localparam int FLG_IO_PRIVILEGE_LEVEL_HI = 13;
    localparam int FLG_NEST = 14;
    localparam int FLG_RESUME = 16;
    localparam int FLG_V86 = 17;
    localparam int FLG_VIRQ = 19;
    localparam int FLG_VPEND = 20;
    localparam int CR4_VME_BIT = 0;

    // ==========================================================
    // Classes, vectors, privilege, gate kinds
    localparam logic [1:0] CLASS_ONE = 2'h1;
    localparam logic [1:0] CLASS_TWO = 2'h2;
    localparam logic [1:0] CLASS_THREE = 2'h3;
    localparam logic [7:0] VEC_GP_FAULT = 8'h0d;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] PRIV_USER = 2'h3;
    localparam logic [1:0] IO_PRIVILEGE_LEVEL_FULL = 2'h3;
    localparam logic [1:0] GATE_INTR = 2'h0;
    localparam logic [1:0] GATE_TRAP = 2'h1;
    localparam logic [1:0] GATE_TASK = 2'h2;

    // ==========================================================
    // Save frame: slot indices and count
    localparam int SAVE_SLOTS = 9;
    localparam logic [3:0] SLOT_IP = 4'h0;
    localparam logic [3:0] SLOT_CS = 4'h1;
    localparam logic [3:0] SLOT_FLAGS = 4'h2;
    localparam logic [3:0] SLOT_SP = 4'h3;
    localparam logic [3:0] SLOT_SS = 4'h4;
    localparam logic [3:0] SLOT_ES = 4'h5;
    localparam logic [3:0] SLOT_DS = 4'h6;
    localparam logic [3:0] SLOT_FS = 4'h7;
    localparam logic [3:0] SLOT_GS = 4'h8;
    localparam logic [3:0] SLOT_LAST = 4'h8;

    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [15:0] SEG_NULL = 16'h0000;

    typedef enum logic [2:0] {
        VID_IDLE, VID_CHECK, VID_SWITCH, VID_PUSH, VID_CLEAR, VID_RUN
    } vid_state_t;

endpackage

// file: rtl/vid_classify.sv
// Event classifier for compatibility-mode dispatch.
// Assumes event inputs are one-cycle strobes on the core clock.
`timescale 1ns/10ps
module vid_classify (
    // Event source
    input wire logic i_is_exception,
    input wire logic i_is_nmi,
    input wire logic i_is_maskable,
    input wire logic i_is_soft_int,
    input wire logic [7:0] i_vector,
    // Control state
    input wire logic i_vme_on,
    input wire logic [1:0] i_io_privilege_level,
    input wire logic [255:0] i_redir_map,
    // Result
    output logic [1:0] o_class,
    output logic o_breakpoint,
    output logic o_redirect,
    output logic o_virq_active
);
    always_comb begin
        o_virq_active = i_vme_on && (i_io_privilege_level != vid_pkg::IO_PRIVILEGE_LEVEL_FULL);
        o_breakpoint = i_is_soft_int && (i_vector == vid_pkg::VEC_BREAKPOINT);
        // Bitmap flag clear means the program's own handler takes it
        o_redirect = i_is_soft_int && i_vme_on && !i_redir_map[i_vector];
        if (i_is_soft_int) begin
            o_class = vid_pkg::CLASS_THREE;
        end else if (i_is_maskable && i_vme_on) begin
            o_class = vid_pkg::CLASS_TWO;
        end else if (i_is_exception || i_is_nmi || i_is_maskable) begin
            o_class = vid_pkg::CLASS_ONE;
        end else begin
            o_class = 2'h0;
        end
    end
endmodule // vid_classify

// file: bench/vid_gate_model.sv
// Descriptor table model: answers with the gate for the held vector.
// Assumes the bench holds the vector until the gate check is over.
`timescale 1ns/10ps
module vid_gate_model (
    // Lookup
    input wire logic [7:0] i_vector,
    // Faults ordered by the bench
    input wire logic i_bad_conf,
    input wire logic i_bad_dpl,
    // Gate descriptor
    output logic [1:0] o_gate_kind,
    output logic o_conforming,
    output logic [1:0] o_target_dpl,
    output logic [15:0] o_selector
);
    // ==========================================
    // Gate lookup
    // Vectors f0-ff task gates, odd trap gates, even interrupt gates
    assign o_gate_kind = (i_vector[7:4] == 4'hf) ? vid_pkg::GATE_TASK :
        (i_vector[0] ? vid_pkg::GATE_TRAP : vid_pkg::GATE_INTR);
    assign o_conforming = i_bad_conf;
    assign o_target_dpl = i_bad_dpl ? 2'h3 : vid_pkg::PRIV_KERNEL;
    assign o_selector = {i_vector, 8'h08};
endmodule // vid_gate_model

// file: bench/vid_dispatch_tb.sv
// Testbench for the compatibility-mode dispatch block.
// Assumes the gate model drives the descriptor inputs.
`timescale 1ns/10ps
module vid_dispatch_tb;
    // ==========================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, fl_en = 1'b0, interrupt_return_instr = 1'b0, bconf = 1'b0, bdpl = 1'b0;
    logic exc = 1'b0, nmi = 1'b0, msk = 1'b0, sw = 1'b0;
    logic [7:0] vec = 8'h00;
    logic [15:0] seg = 16'h1100;
    logic [31:0] cr4 = 32'h0, fl_ld = 32'h0, ifl = 32'h0, fexp = 32'h0;
    logic [255:0] map = '1;
    logic [1:0] gk, gd, current_privilege_level, cls;
    logic gc, p32, bp, redir, tsk, gp, hst, busy, pv;
    logic [15:0] gsel, gpe, es, ds, fs, gs;
    logic [31:0] flags, pdata;
    logic [3:0] pslot;
    logic [7:0] hv;
    int n_errors = 0, tests_run = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    vid_gate_model GM (.i_vector(vec), .i_bad_conf(bconf), .i_bad_dpl(bdpl),
        .o_gate_kind(gk), .o_conforming(gc), .o_target_dpl(gd), .o_selector(gsel));
    vid_dispatch DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_exc_evt(exc), .i_nmi_evt(nmi),
        .i_maskable_evt(msk), .i_soft_int_evt(sw), .i_vector(vec), .i_control_reg_four(cr4),
        .i_redir_map(map), .i_gate_kind(gk), .i_gate_conforming(gc), .i_gate_target_dpl(gd),
        .i_gate_selector(gsel), .i_instruction_pointer({16'h0, seg} + 32'h10),
        .i_stack_pointer({seg, 16'h0}), .i_cs(seg + 16'h5), .i_ss(seg + 16'h6),
        .i_es(seg + 16'h1), .i_ds(seg + 16'h2), .i_fs(seg + 16'h3), .i_gs(seg + 16'h4),
        .i_flags_load(fl_ld), .i_flags_load_en(fl_en), .i_interrupt_return_instr_req(interrupt_return_instr), .i_interrupt_return_instr_flags(ifl),
        .i_interrupt_return_instr_es(seg + 16'h8), .i_interrupt_return_instr_ds(seg + 16'h9), .i_interrupt_return_instr_fs(seg + 16'ha),
        .i_interrupt_return_instr_gs(seg + 16'hb), .o_flags_register(flags), .o_current_privilege_level(current_privilege_level),
        .o_prot32(p32), .o_event_class(cls), .o_breakpoint(bp), .o_redirect_to_program(redir),
        .o_task_switch_req(tsk), .o_gp_fault(gp), .o_gp_error_code(gpe),
        .o_handler_vector(hv), .o_handler_start(hst), .o_busy(busy), .o_push_valid(pv),
        .o_push_slot(pslot), .o_push_data(pdata), .o_es(es), .o_ds(ds), .o_fs(fs), .o_gs(gs));

    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] pexp(input int s);
        case (s)
            0: return {16'h0, seg} + 32'h10;
            1: return {16'h0, seg + 16'h5};
            2: return fexp;
            3: return {seg, 16'h0};
            4: return {16'h0, seg + 16'h6};
            default: return {16'h0, seg + 16'(s - 4)};
        endcase
    endfunction

    task automatic ldf(input logic [31:0] val);
        @(posedge clk);
        fl_ld <= val;
        fl_en <= 1'b1;
        @(posedge clk);
        fl_en <= 1'b0;
        fexp = val;
    endtask

    // Path: 0 gate entry, 1 fault, 2 task gate, 3 redirect, 4 class only
    task automatic ev(input int kind, input logic [7:0] v, input logic [1:0] ecls, input int path);
        int pushes = 0;
        int ngp = 0;
        int ntsk = 0;
        int nst = 0;
        ldf(32'h0003_7302);
        @(posedge clk);
        vec <= v;
        seg <= {v, 8'h00};
        {exc, nmi, msk, sw} <= 4'h8 >> kind;
        @(posedge clk);
        {exc, nmi, msk, sw} <= 4'h0;
        for (int k = 1; k <= 20; k++) begin
            #1;
            if (k == 1) begin
                chk("class", ecls, cls);
                chk("breakpoint", v == 8'h03 && kind == 3, bp);
                chk("redirect", path == 3, redir);
            end
            if (gp === 1'b1) begin
                ngp++;
                chk("gp_code", {v, 8'h08}, gpe);
                chk("gp_vector", vid_pkg::VEC_GP_FAULT, hv);
            end
            ntsk += (tsk === 1'b1);
            if (pv === 1'b1) begin
                chk("push_slot", pushes, pslot);
                chk("push_data", pexp(pushes), pdata);
                pushes++;
            end
            if (hst === 1'b1) begin
                nst++;
                chk("start_cycle", 14, k);
                chk("handler_vector", v, hv);
                chk("flags", fexp & ~(v[0] ? 32'h0003_4100 : 32'h0003_4300), flags);
                chk("segments", 64'h0, {es, ds, fs, gs});
                chk("privilege", 2'h0, current_privilege_level);
                chk("prot32", 1'b1, p32);
            end
            @(posedge clk);
        end
        #1;
        if (path != 4) begin
            chk("push_count", path == 0 ? 9 : 0, pushes);
            chk("gp_count", path == 1, ngp);
            chk("task_count", path == 2, ntsk);
            chk("start_count", path == 0, nst);
        end
        chk("busy", 1'b0, busy);
    endtask

    task automatic ret(input logic [31:0] img, input logic m, input logic [1:0] vf,
        input logic [1:0] ecpl);
        @(posedge clk);
        ifl <= img;
        interrupt_return_instr <= 1'b1;
        @(posedge clk);
        interrupt_return_instr <= 1'b0;
        #1;
        chk("mode", m, flags[17]);
        chk("virtual", vf, flags[20:19]);
        chk("ret_priv", ecpl, current_privilege_level);
        chk("ret_segs", {seg + 16'h8, seg + 16'h9, seg + 16'ha, seg + 16'hb},
            {es, ds, fs, gs});
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================
    // Sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset_flags", vid_pkg::FLAGS_RESET, flags);
        chk("reset_state", 4'h0, {current_privilege_level, p32, busy});
        @(posedge clk);
        exc <= 1'b1;
        @(posedge clk);
        exc <= 1'b0;
        #1;
        chk("ignored", 1'b0, busy);
        ev(0, 8'h0e, vid_pkg::CLASS_ONE, 0);
        ret(32'h0002_3202, 1'b1, 2'h0, 2'h3);
        ret(32'h0018_0202, 1'b1, 2'h0, 2'h3);
        @(posedge clk);
        cr4 <= 32'h1;
        map <= ~(256'h1 << 8'h40);
        ret(32'h0018_0202, 1'b1, 2'h3, 2'h3);
        ev(2, 8'h31, vid_pkg::CLASS_TWO, 4);
        ev(3, 8'h40, vid_pkg::CLASS_THREE, 3);
        ev(3, 8'h41, vid_pkg::CLASS_THREE, 4);
        @(posedge clk);
        cr4 <= 32'h0;
        ev(3, 8'h40, vid_pkg::CLASS_THREE, 4);
        ev(3, 8'h03, vid_pkg::CLASS_THREE, 4);
        ev(2, 8'h20, vid_pkg::CLASS_ONE, 0);
        ev(1, 8'h21, vid_pkg::CLASS_ONE, 0);
        @(posedge clk);
        bconf <= 1'b1;
        ev(0, 8'h10, vid_pkg::CLASS_ONE, 1);
        @(posedge clk);
        bconf <= 1'b0;
        bdpl <= 1'b1;
        ev(0, 8'h12, vid_pkg::CLASS_ONE, 1);
        @(posedge clk);
        bdpl <= 1'b0;
        ev(0, 8'hf0, vid_pkg::CLASS_ONE, 2);
        wrap_up();
    end

    // Watchdog, well beyond the few hundred cycles the tests take
    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end
endmodule // vid_dispatch_tb
